// ### design/vir_top.sv
// Vectored interrupt router: APB register file, polarity, routing, masking, vectors
//
// How it works
// RULE1 - Every input keeps its own target bit choosing exactly one processor line.
// RULE2 - Target value 0 sends the input to the fast interrupt line.
// RULE3 - Target value 1 sends the input to the standard interrupt line.
// RULE4 - Each target masks requests by comparing their priority with its own threshold.
// RULE5 - An input of priority 0 never raises any line, whatever the threshold.
// RULE6 - Priority 1 ranks lowest among active requests.
// RULE7 - Priority 15 ranks highest, so four bits span masked to highest.
// RULE8 - Software may raise any input, which is then routed and masked like hardware.
// RULE9 - Inputs are level active, each through a programmable polarity.
// RULE10 - There are 56 request inputs, each with target, priority and software request.
// RULE11 - Software reads each input's state before masking.
// RULE12 - Each target shows a vector naming its pending request.
// RULE13 - A line is high while a routed request beats its threshold; vector is the best.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module vir_top
    import vir_pkg::*;
#(
    parameter int N = NUM_INPUTS // RULE10
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic [N-1:0]      irq_in,
    output logic                   fast_interrupt_line,
    output logic                   standard_interrupt_line,
    output vir_vec_t               fast_vector,
    output vir_vec_t               std_vector,
    output logic                   event_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers
    function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
        return (a >= OFS_CFG_BASE) && (a <= OFS_CFG_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [IDX_W-1:0] cfg_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_CFG_BASE;
        return d[IDX_W+1:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [PRIO_W-1:0] prio_reg [N];
    logic [N-1:0]      tgt_reg;
    logic [N-1:0]      pol_reg;
    logic [N-1:0]      swreq_reg;
    logic [PRIO_W-1:0] thr_fast_reg;
    logic [PRIO_W-1:0] thr_std_reg;
    logic [1:0]        evt_stat_reg;
    logic [1:0]        evt_mask_reg;
    logic [N-1:0]      raw_reg;
    vir_apb_rsp_t      rsp_reg;
    vir_apb_rsp_t      rsp_next;
    vir_vec_t          vec_fast_reg;
    vir_vec_t          vec_std_reg;
    vir_vec_t          vec_fast_next;
    vir_vec_t          vec_std_next;
    logic              line_fast_reg;
    logic              line_std_reg;
    logic              event_irq_reg;

    logic              setup;
    logic              wr_take;
    logic [N-1:0]      req_eff;
    logic [1:0]        evt_set;
    logic [1:0]        evt_stat_next;

    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite && (pstrb != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Request conditioning
    assign req_eff = (irq_in ^ pol_reg) | swreq_reg; // RULE9 RULE8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_reg <= '0;
        end else begin
            raw_reg <= req_eff; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-input configuration
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_cfg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prio_reg[gi]  <= RST_PRIO;
                    tgt_reg[gi]   <= TGT_FAST;
                    pol_reg[gi]   <= 1'b0;
                    swreq_reg[gi] <= 1'b0;
                end else if (wr_take && is_cfg(paddr)
                             && (cfg_idx(paddr) == IDX_W'(gi))) begin
                    if (pstrb[0]) begin
                        prio_reg[gi] <= pwdata[FLD_PRIO_LSB +: PRIO_W];
                    end
                    if (pstrb[1]) begin
                        tgt_reg[gi] <= pwdata[FLD_TGT]; // RULE1
                    end
                    if (pstrb[2]) begin
                        pol_reg[gi] <= pwdata[FLD_POL];
                    end
                    if (pstrb[3]) begin
                        swreq_reg[gi] <= pwdata[FLD_SWREQ]; // RULE8
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Thresholds and event mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_fast_reg <= RST_THR;
            thr_std_reg  <= RST_THR;
            evt_mask_reg <= RST_EVT;
        end else if (wr_take && pstrb[0]) begin
            if (paddr == OFS_THR_FAST) begin
                thr_fast_reg <= pwdata[PRIO_W-1:0]; // RULE4
            end else if (paddr == OFS_THR_STD) begin
                thr_std_reg <= pwdata[PRIO_W-1:0]; // RULE4
            end else if (paddr == OFS_EVT_MASK) begin
                evt_mask_reg <= pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration per target
    always_comb begin
        vec_fast_next = '0;
        vec_std_next  = '0;
        for (int i = 0; i < N; i++) begin
            if (req_eff[i] && tgt_reg[i] == TGT_FAST                // RULE2
                && prio_reg[i] > thr_fast_reg                       // RULE4 RULE5 RULE13
                && (!vec_fast_next.valid || prio_reg[i] > vec_fast_next.prio)) begin // RULE6 RULE7
                vec_fast_next.valid = 1'b1;
                vec_fast_next.prio  = prio_reg[i];
                vec_fast_next.idx   = IDX_W'(i);
            end
            if (req_eff[i] && tgt_reg[i] == TGT_STD                 // RULE3
                && prio_reg[i] > thr_std_reg                        // RULE4 RULE5 RULE13
                && (!vec_std_next.valid || prio_reg[i] > vec_std_next.prio)) begin // RULE6 RULE7
                vec_std_next.valid = 1'b1;
                vec_std_next.prio  = prio_reg[i];
                vec_std_next.idx   = IDX_W'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_fast_reg  <= '0;
            vec_std_reg   <= '0;
            line_fast_reg <= 1'b0;
            line_std_reg  <= 1'b0;
        end else begin
            vec_fast_reg  <= vec_fast_next; // RULE12
            vec_std_reg   <= vec_std_next;  // RULE12
            line_fast_reg <= vec_fast_next.valid; // RULE13
            line_std_reg  <= vec_std_next.valid;  // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events: line rising edges; set beats write-one clear
    assign evt_set = {vec_std_next.valid & ~line_std_reg,
                      vec_fast_next.valid & ~line_fast_reg};

    always_comb begin
        evt_stat_next = evt_stat_reg | evt_set;
        if (wr_take && pstrb[0] && paddr == OFS_EVT_STAT) begin
            evt_stat_next = (evt_stat_reg & ~pwdata[1:0]) | evt_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat_reg <= RST_EVT;
        end else begin
            evt_stat_reg <= evt_stat_next;
        end
    end

    // Follows the status it is built from, so a clear drops it at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq_reg <= 1'b0;
        end else begin
            event_irq_reg <= |(evt_stat_next & evt_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read and response, answered in the first access cycle
    always_comb begin
        rsp_next       = '0;
        rsp_next.ready = setup;
        if (paddr == OFS_THR_FAST) begin
            rsp_next.rdata[PRIO_W-1:0] = thr_fast_reg;
        end else if (paddr == OFS_THR_STD) begin
            rsp_next.rdata[PRIO_W-1:0] = thr_std_reg;
        end else if (paddr == OFS_VEC_FAST) begin
            rsp_next.rdata[IDX_W-1:0]                     = vec_fast_reg.idx;
            rsp_next.rdata[FLD_VEC_PRIO +: PRIO_W]        = vec_fast_reg.prio;
            rsp_next.rdata[FLD_VEC_VLD]                   = vec_fast_reg.valid;
        end else if (paddr == OFS_VEC_STD) begin
            rsp_next.rdata[IDX_W-1:0]                     = vec_std_reg.idx;
            rsp_next.rdata[FLD_VEC_PRIO +: PRIO_W]        = vec_std_reg.prio;
            rsp_next.rdata[FLD_VEC_VLD]                   = vec_std_reg.valid;
        end else if (paddr == OFS_EVT_STAT) begin
            rsp_next.rdata[1:0] = evt_stat_reg;
        end else if (paddr == OFS_EVT_MASK) begin
            rsp_next.rdata[1:0] = evt_mask_reg;
        end else if (paddr == OFS_RAW_LO) begin
            rsp_next.rdata = raw_reg[31:0]; // RULE11
        end else if (paddr == OFS_RAW_HI) begin
            rsp_next.rdata[N-33:0] = raw_reg[N-1:32]; // RULE11
        end else if (is_cfg(paddr)) begin
            rsp_next.rdata[FLD_PRIO_LSB +: PRIO_W] = prio_reg[cfg_idx(paddr)];
            rsp_next.rdata[FLD_TGT]                = tgt_reg[cfg_idx(paddr)];
            rsp_next.rdata[FLD_POL]                = pol_reg[cfg_idx(paddr)];
            rsp_next.rdata[FLD_SWREQ]              = swreq_reg[cfg_idx(paddr)];
            rsp_next.rdata[FLD_RAW]                = raw_reg[cfg_idx(paddr)];
        end else begin
            rsp_next.slverr = setup;
        end
        if (!setup || pwrite) begin
            rsp_next.rdata = RST_WORD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign pready                  = rsp_reg.ready;
    assign pslverr                 = rsp_reg.slverr;
    assign prdata                  = rsp_reg.rdata;
    assign fast_interrupt_line     = line_fast_reg;
    assign standard_interrupt_line = line_std_reg;
    assign fast_vector             = vec_fast_reg;
    assign std_vector              = vec_std_reg;
    assign event_irq               = event_irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    line_matches_vec_a: assert property (fast_interrupt_line == fast_vector.valid) // RULE13
        else $error("fast line disagrees with its vector");

    std_line_vec_a: assert property (standard_interrupt_line == std_vector.valid) // RULE13
        else $error("standard line disagrees with its vector");

    fast_routing_a: assert property (vec_fast_next.valid |-> // RULE2
            tgt_reg[vec_fast_next.idx] == TGT_FAST && req_eff[vec_fast_next.idx])
        else $error("fast vector names input not routed to fast line");

    std_routing_a: assert property (vec_std_next.valid |-> // RULE3
            tgt_reg[vec_std_next.idx] == TGT_STD && req_eff[vec_std_next.idx])
        else $error("standard vector names input routed elsewhere");

    fast_threshold_a: assert property (fast_vector.valid |-> // RULE4
            fast_vector.prio > $past(thr_fast_reg))
        else $error("fast request not above its threshold");

    std_threshold_a: assert property (std_vector.valid |-> // RULE4
            std_vector.prio > $past(thr_std_reg))
        else $error("standard request not above its threshold");

    thr_write_a: assert property ((wr_take && pstrb[0] && paddr == OFS_THR_STD) |=> // RULE4
            thr_std_reg == $past(pwdata[PRIO_W-1:0]))
        else $error("standard threshold write lost");

    masked_prio_a: assert property ((req_eff[9] && prio_reg[9] == PRIO_MASKED) |=> // RULE5
            !(fast_vector.valid && fast_vector.idx == 6'd9)
            && !(std_vector.valid && std_vector.idx == 6'd9))
        else $error("priority zero input raised a line");

    top_prio_a: assert property ((req_eff[12] && prio_reg[12] == PRIO_HIGHEST // RULE7
            && tgt_reg[12] == TGT_FAST && thr_fast_reg != PRIO_HIGHEST)
            |=> fast_interrupt_line && fast_vector.prio == PRIO_HIGHEST)
        else $error("highest priority request not taken");

    lowest_prio_a: assert property ((fast_vector.valid // RULE6
            && fast_vector.prio == PRIO_LOWEST)
            |-> thr_fast_reg == PRIO_MASKED || $changed(thr_fast_reg))
        else $error("lowest priority passed a nonzero threshold");

    sw_request_a: assert property ((swreq_reg[55] && tgt_reg[55] == TGT_STD // RULE8
            && prio_reg[55] > thr_std_reg) |=> standard_interrupt_line)
        else $error("software request not routed");

    polarity_raw_a: assert property (##1 raw_reg[20] == // RULE9 RULE11
            (($past(irq_in[20]) ^ $past(pol_reg[20])) | $past(swreq_reg[20])))
        else $error("raw state not polarity corrected");

    apb_answer_a: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");

    apb_error_a: assert property (pslverr |-> pready)
        else $error("error answer outside the access cycle");

    idle_rdata_a: assert property (!pready |-> prdata == RST_WORD)
        else $error("read data driven outside the access cycle");

    event_sticky_a: assert property ($rose(fast_interrupt_line) |-> evt_stat_reg[0])
        else $error("fast line rise not recorded");

    // Every passing request must be matched or beaten by the vector, ties to lower index
    generate
        for (gi = 0; gi < N; gi++) begin : g_chk
            fast_best_a: assert property ((req_eff[gi] && tgt_reg[gi] == TGT_FAST // RULE13
                    && prio_reg[gi] > thr_fast_reg) |=> fast_vector.valid
                    && fast_vector.prio >= $past(prio_reg[gi])
                    && (fast_vector.prio != $past(prio_reg[gi])
                        || fast_vector.idx <= IDX_W'(gi)))
                else $error("fast vector lost to a weaker request");
            std_best_a: assert property ((req_eff[gi] && tgt_reg[gi] == TGT_STD // RULE13
                    && prio_reg[gi] > thr_std_reg) |=> std_vector.valid
                    && std_vector.prio >= $past(prio_reg[gi])
                    && (std_vector.prio != $past(prio_reg[gi])
                        || std_vector.idx <= IDX_W'(gi)))
                else $error("standard vector lost to a weaker request");
        end
    endgenerate

    fast_seen_c: cover property ($rose(fast_interrupt_line));
    tie_win_c: cover property (req_eff[12] && req_eff[30] && fast_vector.idx == 6'd12);
    std_seen_c: cover property ($rose(standard_interrupt_line));
    both_lines_c: cover property (fast_interrupt_line && standard_interrupt_line);
    event_irq_c: cover property ($rose(event_irq));

endmodule

// ### design/vir_pkg.sv
// Package: constants and carrier types of the vectored interrupt router
package vir_pkg;
    localparam int          NUM_INPUTS   = 56;
    localparam int          PRIO_W       = 4;
    localparam int          IDX_W        = 6;
    localparam int          ADDR_W       = 12;
    localparam logic [3:0]  PRIO_MASKED  = 4'h0;
    localparam logic [3:0]  PRIO_LOWEST  = 4'h1;
    localparam logic [3:0]  PRIO_HIGHEST = 4'hF;
    localparam logic        TGT_FAST     = 1'b0;
    localparam logic        TGT_STD      = 1'b1;

    // Register byte offsets
    localparam logic [11:0] OFS_THR_FAST  = 12'h000;
    localparam logic [11:0] OFS_THR_STD   = 12'h004;
    localparam logic [11:0] OFS_VEC_FAST  = 12'h008;
    localparam logic [11:0] OFS_VEC_STD   = 12'h00C;
    localparam logic [11:0] OFS_EVT_STAT  = 12'h010;
    localparam logic [11:0] OFS_EVT_MASK  = 12'h014;
    localparam logic [11:0] OFS_RAW_LO    = 12'h018;
    localparam logic [11:0] OFS_RAW_HI    = 12'h01C;
    localparam logic [11:0] OFS_CFG_BASE  = 12'h100;
    localparam logic [11:0] OFS_CFG_LAST  = 12'h1DC;

    // Per-input configuration word fields
    localparam int FLD_PRIO_LSB = 0;
    localparam int FLD_TGT      = 8;
    localparam int FLD_POL      = 16;
    localparam int FLD_SWREQ    = 24;
    localparam int FLD_RAW      = 31;
    // Vector word fields
    localparam int FLD_VEC_PRIO = 8;
    localparam int FLD_VEC_VLD  = 31;

    // Reset values
    localparam logic [3:0]  RST_PRIO    = 4'h0;
    localparam logic [3:0]  RST_THR     = 4'h0;
    localparam logic [1:0]  RST_EVT     = 2'h0;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    typedef struct packed {
        logic             valid;
        logic [3:0]       prio;
        logic [5:0]       idx;
    } vir_vec_t;

    typedef struct packed {
        logic             ready;
        logic             slverr;
        logic [31:0]      rdata;
    } vir_apb_rsp_t;
endpackage

// ### tb/vir_cpu_model.sv
// Processor side model: counts entries taken on each interrupt line
`timescale 1ns/100ps
module vir_cpu_model
    import vir_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     fast_line,
    input  wire logic     std_line,
    input  wire vir_vec_t fast_vec,
    input  wire vir_vec_t std_vec,
    output logic [7:0]    fast_taken,
    output logic [7:0]    std_taken,
    output vir_vec_t      last_vec
);
    logic fast_q;
    logic std_q;

    ////////////////////////////////////////////////////////////////////////
    // A new entry is taken on each rising level; the vector is latched then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_q     <= 1'b0;
            std_q      <= 1'b0;
            fast_taken <= 8'h00;
            std_taken  <= 8'h00;
            last_vec   <= '0;
        end else begin
            fast_q <= fast_line;
            std_q  <= std_line;
            // Both lines may rise together; the fast entry is latched last
            if (std_line && !std_q) begin
                std_taken <= std_taken + 8'h01;
                last_vec  <= std_vec;
            end
            if (fast_line && !fast_q) begin
                fast_taken <= fast_taken + 8'h01;
                last_vec   <= fast_vec;
            end
        end
    end
endmodule

// ### tb/vectored_interrupt_router_tb.sv
// Self-checking testbench of the vectored interrupt router
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module vectored_interrupt_router_tb
    import vir_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, q;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, fast_interrupt_line, standard_interrupt_line, event_irq, err;
    logic [31:0] prdata;
    logic [55:0] irq_in = '0;
    vir_vec_t    fast_vector, std_vector, last_vec;
    logic [7:0]  fast_taken, std_taken;
    int          num_errors = 0, checks_done = 0;

    vir_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .irq_in(irq_in),
        .fast_interrupt_line(fast_interrupt_line),
        .standard_interrupt_line(standard_interrupt_line), .fast_vector(fast_vector),
        .std_vector(std_vector), .event_irq(event_irq));

    vir_cpu_model cpu (.pclk(pclk), .presetn(presetn), .fast_line(fast_interrupt_line),
        .std_line(standard_interrupt_line), .fast_vec(fast_vector), .std_vec(std_vector),
        .fast_taken(fast_taken), .std_taken(std_taken), .last_vec(last_vec));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= wr ? 4'hF : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            end_sim();
        end
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input int i, input logic [3:0] p, input logic t, input logic pol,
                       input logic sw);
        apb(1'b1, OFS_CFG_BASE + 12'(4 * i), {7'h00, sw, 7'h00, pol, 7'h00, t, 4'h0, p});
    endtask

    task automatic irq(input int i, input logic v);
        @(posedge pclk);
        irq_in[i] <= v;
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    function automatic vir_vec_t vec(input logic [3:0] p, input logic [5:0] i);
        return '{valid: 1'b1, prio: p, idx: i};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        apb(1'b0, OFS_CFG_BASE, 32'h0000_0000); `CHK(q, RST_WORD)
        apb(1'b0, OFS_THR_FAST, 32'h0000_0000); `CHK(q, RST_WORD)
        apb(1'b0, 12'h020, 32'h0000_0000); `CHK({err, q}, 33'h1_0000_0000)
        // Input 5 to the standard line
        cfg(5, 4'h3, TGT_STD, 1'b0, 1'b0);
        irq(5, 1'b1);
        settle();
        `CHK({standard_interrupt_line, fast_interrupt_line}, 2'b10)
        `CHK(std_vector, vec(4'h3, 6'd5))
        `CHK(fast_vector.valid, 1'b0)
        apb(1'b0, OFS_VEC_STD, 32'h0000_0000); `CHK(q, 32'h8000_0305)
        // Event status, mask and clear
        `CHK(event_irq, 1'b0)
        apb(1'b0, OFS_EVT_STAT, 32'h0000_0000); `CHK(q, 32'h0000_0002)
        apb(1'b1, OFS_EVT_MASK, 32'h0000_0002);
        settle(); `CHK(event_irq, 1'b1)
        apb(1'b1, OFS_EVT_STAT, 32'h0000_0002);
        settle(); `CHK(event_irq, 1'b0)
        // Threshold compare on the standard target
        apb(1'b1, OFS_THR_STD, 32'h0000_0003);
        settle(); `CHK(standard_interrupt_line, 1'b0)
        apb(1'b1, OFS_THR_STD, 32'h0000_0002);
        settle(); `CHK(standard_interrupt_line, 1'b1)
        apb(1'b1, OFS_THR_STD, 32'h0000_0000);
        // Priority zero stays silent
        irq(9, 1'b1);
        settle(); `CHK(fast_interrupt_line, 1'b0)
        // Fast line, ranking and ties
        cfg(7, 4'h1, TGT_FAST, 1'b0, 1'b0);
        irq(7, 1'b1);
        settle(); `CHK(fast_vector, vec(4'h1, 6'd7))
        `CHK(fast_interrupt_line, 1'b1)
        cfg(12, 4'hF, TGT_FAST, 1'b0, 1'b0);
        cfg(30, 4'hF, TGT_FAST, 1'b0, 1'b0);
        irq(30, 1'b1);
        irq(12, 1'b1);
        apb(1'b1, OFS_THR_FAST, 32'h0000_000E);
        settle(); `CHK(fast_vector, vec(4'hF, 6'd12))
        `CHK(fast_interrupt_line, 1'b1)
        // Inverted polarity makes a low input active
        cfg(20, 4'h2, TGT_STD, 1'b1, 1'b0);
        settle();
        apb(1'b0, OFS_RAW_LO, 32'h0000_0000); `CHK(q, 32'h4010_12A0)
        `CHK(std_vector, vec(4'h3, 6'd5))
        // Software request on the last input
        cfg(55, 4'h4, TGT_STD, 1'b0, 1'b1);
        settle(); `CHK(std_vector, vec(4'h4, 6'd55))
        apb(1'b0, OFS_RAW_HI, 32'h0000_0000); `CHK(q, 32'h0080_0000)
        apb(1'b0, OFS_CFG_BASE + 12'h0DC, 32'h0000_0000); `CHK(q, 32'h8100_0104)
        `CHK({fast_taken, std_taken}, 16'h0102)
        `CHK(last_vec, vec(4'h1, 6'd7))
        end_sim();
    end
endmodule
